// ---- hw/gpc_pkg.sv ----
// Shared constants and types for the GPIO pin configuration block
package gpc_pkg;

  // ==========================================================
  // Register map (byte addresses on the APB bus)
  localparam logic [15:0] GPC_ADDR_OUT_CFG = 16'ha100;
  localparam logic [15:0] GPC_ADDR_IN_CFG = 16'ha110;

  // ==========================================================
  // Reset values
  localparam logic [7:0] GPC_OUT_CFG_RST = 8'h00;
  localparam logic [7:0] GPC_IN_CFG_RST = 8'h00;

  // ==========================================================
  // Input configuration field positions
  localparam int GPC_IN_RISE_POS = 5;
  localparam int GPC_IN_FALL_POS = 4;
  localparam int GPC_IN_FILT_POS = 1;
  localparam int GPC_IN_RAW_POS = 0;

  // ==========================================================
  // De-bounce stability times, in slow oscillator periods
  localparam logic [1:0] GPC_DBN_OFF = 2'h0;
  localparam logic [1:0] GPC_DBN_4 = 2'h1;
  localparam logic [1:0] GPC_DBN_16 = 2'h2;
  localparam logic [6:0] GPC_DBN_CNT_4 = 7'h04;
  localparam logic [6:0] GPC_DBN_CNT_16 = 7'h10;
  localparam logic [6:0] GPC_DBN_CNT_64 = 7'h40;

  // ==========================================================
  // Types
  typedef struct packed {
    logic fast_edge_drive;
    logic high_side_driver_en;
    logic low_side_driver_en;
    logic out_invert;
    logic analog_path_b_en;
    logic analog_path_a_en;
    logic pull_high_en;
    logic pull_low_en;
  } gpc_out_cfg_t;

  typedef struct packed {
    logic irq_line_b_en;
    logic irq_line_a_en;
    logic rise_irq_en;
    logic fall_irq_en;
    logic input_buffer_en;
    logic in_invert;
    logic [1:0] filter_time_sel;
  } gpc_in_cfg_t;

  typedef struct packed {
    logic irq_line_b;
    logic irq_line_a;
    logic wake_req;
  } gpc_irq_t;

  typedef enum logic [1:0] {GPC_REG_NONE, GPC_REG_OUT, GPC_REG_IN} gpc_reg_t;

endpackage : gpc_pkg

// ---- hw/gpc_edge_detect.sv ----
// Rising and falling edge detector for the filtered pin level
`timescale 1ns/1ps
module gpc_edge_detect
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Level in, edge pulses out
  input wire logic level,
  output logic rise,
  output logic fall
);
  import gpc_pkg::*;

  logic prev;
  logic next_prev;

  // ==========================================================
  // Previous level
  always_comb
  begin
    next_prev = level;
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      prev <= 1'b0;
    else
      prev <= next_prev;
  end

  // One registered previous level, compared combinationally with level, feeds both the rise and fall pulses
  assign rise = level && !prev;
  assign fall = !level && prev;

endmodule : gpc_edge_detect

// ---- hw/gpc_debounce.sv ----
// De-bounce filter counted in slow oscillator periods
`timescale 1ns/1ps
module gpc_debounce
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Timing
  input wire logic tick,
  input wire logic [1:0] sel,
  // Levels
  input wire logic din,
  output logic dout
);
  import gpc_pkg::*;

  logic [6:0] cnt;
  logic [6:0] next_cnt;
  logic next_dout;
  logic [6:0] lim;

  // ==========================================================
  // Stability time for a selection code
  function automatic logic [6:0] dbn_limit(input logic [1:0] code);
    unique case (code)
      GPC_DBN_OFF: dbn_limit = 7'h00;
      GPC_DBN_4: dbn_limit = GPC_DBN_CNT_4;
      GPC_DBN_16: dbn_limit = GPC_DBN_CNT_16;
      default: dbn_limit = GPC_DBN_CNT_64;
    endcase
  endfunction : dbn_limit

  assign lim = dbn_limit(sel);

  // ==========================================================
  // Count slow periods while the input differs from the output
  always_comb
  begin
    next_cnt = cnt;
    next_dout = dout;
    if (sel == GPC_DBN_OFF)
    begin
      next_dout = din;
      next_cnt = 7'h00;
    end
    else if (din == dout)
      next_cnt = 7'h00; // Bounce back restarts
    else if (tick)
    begin
      if (cnt == lim - 7'h01)
      begin
        next_dout = din;
        next_cnt = 7'h00;
      end
      else
        next_cnt = cnt + 7'h01;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      cnt <= 7'h00;
      dout <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      dout <= next_dout;
    end
  end

  // ==========================================================
  // Checks
  a_filter_accept: assert property (@(posedge clk) disable iff (!reset_n)
    ($past(sel) != GPC_DBN_OFF && dout != $past(dout))
      |-> ($past(tick) && $past(cnt) == $past(lim) - 7'h01))
    else $error("filtered level changed before stability time");

  a_filter_bypass: assert property (@(posedge clk) disable iff (!reset_n)
    (sel == GPC_DBN_OFF) |=> (dout == $past(din)))
    else $error("filter off but output does not follow input");

endmodule : gpc_debounce

// ---- hw/gpc_pin_ctrl.sv ----
// GPIO pin configuration with edge flags, de-bounce and an APB slave
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
module gpc_pin_ctrl
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pad
  input wire logic pad_in,
  output logic pad_out,
  output logic pad_oe_n,
  output gpc_pkg::gpc_out_cfg_t pin_output_config,
  // Core side
  input wire logic out_data,
  input wire logic slow_osc,
  output logic filtered_level,
  output gpc_pkg::gpc_irq_t irq
);
  import gpc_pkg::*;

  // ==========================================================
  // Declarations
  gpc_in_cfg_t pin_input_config;
  gpc_in_cfg_t next_in_cfg;
  gpc_out_cfg_t next_out_cfg;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic rise_flag;
  logic fall_flag;
  logic next_rise_flag;
  logic next_fall_flag;
  logic next_pad_out;
  logic next_pad_oe_n;
  gpc_irq_t next_irq;
  logic raw_level;
  logic next_raw_level;
  logic slow_prev;
  logic next_slow_prev;
  logic slow_tick;
  logic pol_level;
  logic rise_evt;
  logic fall_evt;
  logic any_line_en;
  logic setup_phase;
  logic access_done;
  logic wr_out;
  logic wr_in;

  // ==========================================================
  // Address decode, shared by read and write paths
  function automatic gpc_reg_t reg_decode(input logic [15:0] addr);
    if (addr == GPC_ADDR_OUT_CFG)
      reg_decode = GPC_REG_OUT;
    else if (addr == GPC_ADDR_IN_CFG)
      reg_decode = GPC_REG_IN;
    else
      reg_decode = GPC_REG_NONE;
  endfunction : reg_decode

  assign setup_phase = psel && !penable;
  assign access_done = psel && penable && pready;
  // Only the low byte lane holds register bits
  assign wr_out = access_done && pwrite && pstrb[0] && (reg_decode(paddr) == GPC_REG_OUT);
  assign wr_in = access_done && pwrite && pstrb[0] && (reg_decode(paddr) == GPC_REG_IN);

  // ==========================================================
  // APB answer: ready one cycle after setup, read data caught at setup
  always_comb
  begin
    next_pready = setup_phase;
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    if (setup_phase)
    begin
      unique case (reg_decode(paddr))
        GPC_REG_OUT: next_prdata[7:0] = pin_output_config;
        GPC_REG_IN:
        begin
          next_prdata[7:0] = pin_input_config; // Enables and polarity bits
          next_prdata[GPC_IN_RISE_POS] = rise_flag;
          next_prdata[GPC_IN_FALL_POS] = fall_flag;
          next_prdata[GPC_IN_FILT_POS] = filtered_level;
          next_prdata[GPC_IN_RAW_POS] = raw_level;
        end
        GPC_REG_NONE: next_pslverr = 1'b1; // Unmapped address
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= next_pready;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // ==========================================================
  // Configuration registers
  always_comb
  begin
    next_out_cfg = pin_output_config;
    next_in_cfg = pin_input_config;
    if (wr_out)
      next_out_cfg = gpc_out_cfg_t'(pwdata[7:0]);
    if (wr_in)
      next_in_cfg = gpc_in_cfg_t'(pwdata[7:0]);
  end

  // Drivers stay off from reset until software sets them
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      pin_output_config <= gpc_out_cfg_t'(GPC_OUT_CFG_RST);
      pin_input_config <= gpc_in_cfg_t'(GPC_IN_CFG_RST);
    end
    else
    begin
      pin_output_config <= next_out_cfg;
      pin_input_config <= next_in_cfg;
    end
  end

  // ==========================================================
  // Pad output path; data and enable registered so they switch together
  always_comb
  begin
    next_pad_out = out_data ^ pin_output_config.out_invert;
    next_pad_oe_n = !(pin_output_config.high_side_driver_en
                      || pin_output_config.low_side_driver_en);
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      pad_out <= 1'b0;
      pad_oe_n <= 1'b1;
    end
    else
    begin
      pad_out <= next_pad_out;
      pad_oe_n <= next_pad_oe_n;
    end
  end

  // ==========================================================
  // Input buffer and slow oscillator edge
  always_comb
  begin
    next_raw_level = pad_in && pin_input_config.input_buffer_en;
    next_slow_prev = slow_osc;
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      raw_level <= 1'b0;
      slow_prev <= 1'b0;
    end
    else
    begin
      raw_level <= next_raw_level;
      slow_prev <= next_slow_prev;
    end
  end

  // One tick per slow oscillator period paces the filter
  assign slow_tick = slow_osc && !slow_prev;
  assign pol_level = raw_level ^ pin_input_config.in_invert;

  gpc_debounce u_debounce (
    .clk(clk),
    .reset_n(reset_n),
    .tick(slow_tick),
    .sel(pin_input_config.filter_time_sel),
    .din(pol_level),
    .dout(filtered_level)
  );

  // Edges come from the filtered level only, never the raw one
  gpc_edge_detect u_edge (
    .clk(clk),
    .reset_n(reset_n),
    .level(filtered_level),
    .rise(rise_evt),
    .fall(fall_evt)
  );

  // ==========================================================
  // Edge flags; an edge in the clearing cycle wins over the clear
  assign any_line_en = pin_input_config.irq_line_a_en || pin_input_config.irq_line_b_en;

  always_comb
  begin
    next_rise_flag = rise_flag;
    next_fall_flag = fall_flag;
    if (wr_in && !pwdata[GPC_IN_RISE_POS])
      next_rise_flag = 1'b0;
    if (wr_in && !pwdata[GPC_IN_FALL_POS])
      next_fall_flag = 1'b0;
    if (rise_evt && pin_input_config.rise_irq_en && any_line_en)
      next_rise_flag = 1'b1;
    if (fall_evt && pin_input_config.fall_irq_en && any_line_en)
      next_fall_flag = 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      rise_flag <= 1'b0;
      fall_flag <= 1'b0;
    end
    else
    begin
      rise_flag <= next_rise_flag;
      fall_flag <= next_fall_flag;
    end
  end

  // ==========================================================
  // Interrupt lines and wake-up request, levels held while a flag stands
  always_comb
  begin
    next_irq.irq_line_a = pin_input_config.irq_line_a_en && (rise_flag || fall_flag);
    next_irq.irq_line_b = pin_input_config.irq_line_b_en && (rise_flag || fall_flag);
    next_irq.wake_req = any_line_en && (rise_flag || fall_flag);
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      irq <= '0;
    else
      irq <= next_irq;
  end

  // ==========================================================
  // Checks
  sequence s_setup;
    psel && !penable;
  endsequence

  sequence s_rise_cause;
    rise_evt && pin_input_config.rise_irq_en && any_line_en;
  endsequence

  a_apb_answer: assert property (@(posedge clk) disable iff (!reset_n)
    s_setup |=> pready ##1 !pready)
    else $error("apb answer not exactly one cycle after setup");

  a_pad_hiz: assert property (@(posedge clk) disable iff (!reset_n)
    (!pin_output_config.high_side_driver_en && !pin_output_config.low_side_driver_en)
      |=> pad_oe_n)
    else $error("pad driven while both drivers disabled");

  a_pad_polarity: assert property (@(posedge clk) disable iff (!reset_n)
    ##1 (pad_out == ($past(out_data) ^ $past(pin_output_config.out_invert))))
    else $error("pad data polarity wrong");

  a_buffer_off_zero: assert property (@(posedge clk) disable iff (!reset_n)
    !pin_input_config.input_buffer_en |=> !raw_level)
    else $error("disabled input buffer not zero");

  a_rise_set: assert property (@(posedge clk) disable iff (!reset_n)
    s_rise_cause |=> rise_flag ##1 (irq.wake_req || !any_line_en))
    else $error("rising edge did not set flag and wake");

  a_rise_clear: assert property (@(posedge clk) disable iff (!reset_n)
    (wr_in && !pwdata[GPC_IN_RISE_POS] && !rise_evt) |=> !rise_flag)
    else $error("rise flag not cleared by enable write");

  a_fall_set: assert property (@(posedge clk) disable iff (!reset_n)
    (fall_evt && pin_input_config.fall_irq_en && any_line_en) |=> fall_flag)
    else $error("falling edge did not set flag");

  a_fall_clear: assert property (@(posedge clk) disable iff (!reset_n)
    (wr_in && !pwdata[GPC_IN_FALL_POS] && !fall_evt) |=> !fall_flag)
    else $error("fall flag not cleared by enable write");

  a_line_request: assert property (@(posedge clk) disable iff (!reset_n)
    ##1 (irq.irq_line_a == ($past(pin_input_config.irq_line_a_en)
                          && ($past(rise_flag) || $past(fall_flag)))))
    else $error("line a request does not follow flags");

  a_read_status: assert property (@(posedge clk) disable iff (!reset_n)
    (s_setup and (reg_decode(paddr) == GPC_REG_IN))
      |=> (prdata[1:0] == {$past(filtered_level), $past(raw_level)}))
    else $error("status bits read back wrong");

endmodule : gpc_pin_ctrl

// ---- tb/gpc_pad_model.sv ----
// Pad and slow oscillator model facing the pin configuration block
`timescale 1ns/1ps
module gpc_pad_model
(
  // Clock
  input wire logic clk,
  // Bench control of the far end
  input wire logic ext_en,
  input wire logic ext_level,
  // Pad as seen by the block
  input wire logic pad_out,
  input wire logic pad_oe_n,
  input wire gpc_pkg::gpc_out_cfg_t pin_output_config,
  output logic pad_in,
  output logic slow_osc
);
  import gpc_pkg::*;
  logic [2:0] div;
  logic junk;
  // ==========================================
  // Slow oscillator: free running, 8 clocks a period
  initial
  begin
    div = 3'h0;
    junk = 1'b0;
  end
  always @(posedge clk)
  begin
    div <= div + 3'h1;
    junk <= ~junk;
  end
  assign slow_osc = div[2];
  // Wire level: outside driver, own driver, pulls, else a changing pattern
  assign pad_in = ext_en ? ext_level :
    !pad_oe_n ? pad_out :
    pin_output_config.pull_high_en ? 1'b1 :
    pin_output_config.pull_low_en ? 1'b0 : junk;
endmodule : gpc_pad_model

// ---- tb/gpc_pin_ctrl_test.sv ----
// Self-checking bench for the GPIO pin configuration block
`timescale 1ns/1ps
module gpc_pin_ctrl_test;
  import gpc_pkg::*;
  logic clk, reset_n, psel, penable, pwrite, pad_in, pad_out, pad_oe_n;
  logic out_data, slow_osc, filtered_level, pready, pslverr, ext_en, ext_level;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic er;
  gpc_out_cfg_t pin_output_config;
  gpc_irq_t irq;
  int err_total, samples_checked, cycles;
  gpc_pin_ctrl dut_u (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe_n(pad_oe_n), .pin_output_config(pin_output_config), .out_data(out_data),
    .slow_osc(slow_osc), .filtered_level(filtered_level), .irq(irq));
  gpc_pad_model pad_u (.clk(clk), .ext_en(ext_en), .ext_level(ext_level),
    .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pin_output_config(pin_output_config),
    .pad_in(pad_in), .slow_osc(slow_osc));
  // ==========================================
  // Clock, 50 ns period
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ==========================================
  // Shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [15:0] a, input logic [7:0] d,
    input logic [3:0] s);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0000_00, d};
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    // No cycle count assumed; only the bench timeout ends a stuck wait
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    apb(1'b1, a, d, 4'hf);
    // One more edge so outputs that follow the config are registered
    @(posedge clk);
  endtask : wr
  task automatic rdchk(input logic [15:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00, 4'h0);
    chk(rd, {24'h0000_00, exp});
  endtask : rdchk
  task automatic pin(input logic v, input int n);
    ext_level <= v;
    repeat (n) @(posedge clk);
  endtask : pin
  // ==========================================
  // Scenarios
  task automatic t_reset();
    chk(pad_oe_n, 1'b1);
    rdchk(GPC_ADDR_OUT_CFG, GPC_OUT_CFG_RST);
    rdchk(GPC_ADDR_IN_CFG, GPC_IN_CFG_RST);
    apb(1'b0, 16'ha104, 8'h00, 4'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0000_0000);
    $display("reset test done");
  endtask : t_reset
  task automatic t_outcfg();
    ext_en <= 1'b0;
    wr(GPC_ADDR_OUT_CFG, 8'ha5);
    rdchk(GPC_ADDR_OUT_CFG, 8'ha5);
    chk(pin_output_config, 8'ha5);
    chk(pad_oe_n, 1'b0);
    apb(1'b1, GPC_ADDR_OUT_CFG, 8'hff, 4'h0);
    rdchk(GPC_ADDR_OUT_CFG, 8'ha5);
    out_data <= 1'b1;
    wr(GPC_ADDR_OUT_CFG, 8'h40);
    chk({pad_oe_n, pad_out}, 2'b01);
    wr(GPC_ADDR_OUT_CFG, 8'h50);
    chk(pad_out, 1'b0);
    wr(GPC_ADDR_OUT_CFG, 8'h02);
    chk(pad_oe_n, 1'b1);
    wr(GPC_ADDR_IN_CFG, 8'h08);
    rdchk(GPC_ADDR_IN_CFG, 8'h0b);
    wr(GPC_ADDR_OUT_CFG, 8'h00);
    ext_en <= 1'b1;
    $display("output test done");
  endtask : t_outcfg
  task automatic t_input();
    wr(GPC_ADDR_IN_CFG, 8'h00);
    pin(1'b1, 4);
    rdchk(GPC_ADDR_IN_CFG, 8'h00);
    wr(GPC_ADDR_IN_CFG, 8'h08);
    rdchk(GPC_ADDR_IN_CFG, 8'h0b);
    wr(GPC_ADDR_IN_CFG, 8'h0c);
    pin(1'b0, 4);
    rdchk(GPC_ADDR_IN_CFG, 8'h0e);
    chk(filtered_level, 1'b1);
    pin(1'b1, 4);
    rdchk(GPC_ADDR_IN_CFG, 8'h0d);
    $display("input test done");
  endtask : t_input
  task automatic t_edges();
    // Drop the inversion and settle the pin first, so no stray edge arms a flag
    wr(GPC_ADDR_IN_CFG, 8'h08);
    pin(1'b0, 4);
    wr(GPC_ADDR_IN_CFG, 8'h78);
    pin(1'b1, 6);
    rdchk(GPC_ADDR_IN_CFG, 8'h6b);
    chk(irq, 3'b011);
    wr(GPC_ADDR_IN_CFG, 8'h58);
    rdchk(GPC_ADDR_IN_CFG, 8'h4b);
    chk(irq, 3'b000);
    pin(1'b0, 6);
    rdchk(GPC_ADDR_IN_CFG, 8'h58);
    pin(1'b1, 6);
    rdchk(GPC_ADDR_IN_CFG, 8'h5b);
    wr(GPC_ADDR_IN_CFG, 8'h98);
    chk(irq, 3'b101);
    wr(GPC_ADDR_IN_CFG, 8'h88);
    rdchk(GPC_ADDR_IN_CFG, 8'h8b);
    chk(irq, 3'b000);
    // Edge enables without any line enable must not set a flag
    wr(GPC_ADDR_IN_CFG, 8'h38);
    pin(1'b0, 6);
    rdchk(GPC_ADDR_IN_CFG, 8'h08);
    wr(GPC_ADDR_IN_CFG, 8'h08);
    $display("edge test done");
  endtask : t_edges
  task automatic t_filter();
    int k;
    int n;
    // Codes 1..3; one tick is 8 clocks, margins of two ticks absorb phase
    for (k = 1; k < 4; k++)
    begin
      n = (k == 1) ? 4 : (k == 2) ? 16 : 64;
      pin(1'b0, 8 * n + 32);
      wr(GPC_ADDR_IN_CFG, {6'h02, k[1:0]});
      pin(1'b1, 8 * (n - 2));
      chk(filtered_level, 1'b0);
      pin(1'b1, 32);
      chk(filtered_level, 1'b1);
    end
    // A dip during counting must restart the count
    wr(GPC_ADDR_IN_CFG, {6'h02, GPC_DBN_4});
    pin(1'b0, 64);
    pin(1'b1, 16);
    pin(1'b0, 16);
    pin(1'b1, 16);
    chk(filtered_level, 1'b0);
    wr(GPC_ADDR_IN_CFG, {6'h02, GPC_DBN_OFF});
    chk(filtered_level, 1'b1);
    pin(1'b0, 3);
    chk(filtered_level, 1'b0);
    $display("filter test done");
  endtask : t_filter
  // ==========================================
  // Timeout: a hang counts as a mismatch
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles > 20000)
    begin
      err_total++;
      wrap_up();
    end
  end
  // ==========================================
  // Main sequence
  initial
  begin
    err_total = 0;
    samples_checked = 0;
    cycles = 0;
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    out_data = 1'b0;
    ext_en = 1'b1;
    ext_level = 1'b0;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_outcfg();
    t_input();
    t_edges();
    t_filter();
    wrap_up();
  end
endmodule : gpc_pin_ctrl_test
